// ---- verilog/repeater_config_mode_control.sv ----
/*
  Configuration control of an eight-lane repeater: strap mode decode, pin-mode settings,
  EEPROM loader acting as SMBus master, and AXI4-Lite register access.
  Assumes straps are static after reset and an EEPROM answers at the standard address.
*/
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
// Operation
// - Strap high slave, float master, low pin
// - EEPROM load runs with no software help
// - Drive SCL only while loading EEPROM
// - Low load request starts the EEPROM load
// - Load request pin keeps its function afterwards
// - Failed load hangs, refuses access, status high
// - Load status high until load has passed
// - Pin mode: one EQ level per group; with CTRL_EQ_OVR set, pin mode takes per-lane EQ from the register instead
// - SMBus modes: per-lane registers, EQ B is address
// - Swing B straps become address bits zero, one
// - Swing A straps become SCL and SDA
// - Slave address comes from four address pins
// - Threshold strap sets detect threshold only; in master mode it is the load request and the threshold stays at THR_DEFAULT
`timescale 1ns/100ps
module repeater_config_mode_control
  import repeater_cfg_pkg::*;
#(
  parameter logic [7:0] SIGNATURE = 8'h5a, // Arbitrary image marker.
  parameter int QTR_CYC = SCL_QTR_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [1:0] config_mode_select_in,
  input wire logic [1:0] eq_level_group_a_in,
  input wire logic [1:0] eq_level_group_b_in,
  input wire logic [3:0] swing_group_a_in,
  input wire logic [3:0] swing_group_b_in,
  input wire logic [1:0] detect_threshold_sel_in,
  input wire logic address_pin_two_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  output logic [1:0] mode_out,
  output logic load_status_out,
  output logic smbus_enable_out,
  output logic [3:0] slave_address_pins_out,
  output logic [15:0] eq_lane_out,
  output logic [31:0] swing_lane_out,
  output logic [1:0] detect_threshold_out,
  output logic sigdet_readback_en_out,
  output logic irq_out,
  input wire logic [ADDR_W-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [ADDR_W-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in
);

  if (QTR_CYC < 1 || QTR_CYC > 255) begin : g_bad_qtr
    $error("QTR_CYC must lie between 1 and 255");
  end

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic scl_prev;
    logic [1:0] boot_cnt;
    logic sampled;
    mode_t mode;
    ld_t ld;
    logic [7:0] div;
    logic [1:0] qtr;
    logic [3:0] bitn;
    logic [3:0] step;
    logic [7:0] sh;
    logic scl_low;
    logic sda_low;
    logic [15:0] eq_reg;
    logic [31:0] sw_reg;
    logic [2:0] ctrl;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] eq_out;
    logic [31:0] sw_out;
    logic [3:0] addr_out;
    logic [1:0] thr_out;
    logic load_status;
    logic smb_en;
    logic irq;
  } state_t;

  state_t q_ff;
  state_t nxt_q;
  logic [1:0] rst_sync_ff;
  logic rst_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and register stage.

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '{mode: MODE_PIN, ld: LD_IDLE, eq_reg: EQ_RESET, sw_reg: SWING_RESET,
                thr_out: THR_DEFAULT, load_status: 1'b1, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    logic tick;
    logic rd;
    logic ack_ph;
    logic sda_s;
    logic refused;
    logic [2:0] irq_clr;
    logic [2:0] ev;
    logic [31:0] merged;
    int idx;
    nxt_q = q_ff;
    tick = (q_ff.div == 8'(QTR_CYC - 1));
    rd = (q_ff.step >= STEP_FIRST_RD);
    ack_ph = (q_ff.bitn == 4'h8);
    sda_s = q_ff.s2[P_SDA];
    refused = 1'b0;
    irq_clr = 3'h0;
    ev = 3'h0;
    merged = 32'h0;
    idx = int'(q_ff.step) - int'(STEP_FIRST_RD);
    nxt_q.s1 = {config_mode_select_in, eq_level_group_a_in, eq_level_group_b_in,
                swing_group_a_in, swing_group_b_in, detect_threshold_sel_in,
                address_pin_two_in, scl_in, sda_in};
    nxt_q.s2 = q_ff.s1;
    nxt_q.scl_prev = q_ff.s2[P_SCL];
    // The wait lets the pin synchronisers fill before the mode is latched for good.
    if (!q_ff.sampled) begin
      nxt_q.boot_cnt = q_ff.boot_cnt + 2'h1;
      if (q_ff.boot_cnt == BOOT_WAIT) begin
        nxt_q.sampled = 1'b1;
        nxt_q.mode = mode_decode(q_ff.s2[P_MODE +: 2]);
      end
    end

    // EEPROM loader: four clock quarters per SCL bit.
    if (q_ff.ld inside {LD_START, LD_BIT, LD_STOP}) begin
      nxt_q.div = tick ? 8'h0 : q_ff.div + 8'h1;
      if (tick) nxt_q.qtr = q_ff.qtr + 2'h1;
    end else begin
      nxt_q.div = 8'h0;
      nxt_q.qtr = 2'h0;
    end
    unique case (q_ff.ld)
      LD_IDLE: begin
        nxt_q.scl_low = 1'b0;
        nxt_q.sda_low = 1'b0;
        if (q_ff.sampled && q_ff.mode == MODE_MASTER && q_ff.s2[P_THR +: 2] == LVL_0) begin
          nxt_q.ld = LD_START;
          nxt_q.step = 4'h0;
        end
      end
      LD_START: if (tick) begin
        unique case (q_ff.qtr)
          2'h0: nxt_q.sda_low = 1'b0;
          2'h1: nxt_q.scl_low = 1'b0;
          2'h2: nxt_q.sda_low = 1'b1;
          2'h3: begin
            nxt_q.scl_low = 1'b1;
            nxt_q.ld = LD_BIT;
            nxt_q.bitn = 4'h0;
            nxt_q.sh = (q_ff.step == 4'h0) ? EE_WR_CMD : EE_RD_CMD;
          end
        endcase
      end
      LD_BIT: if (tick) begin
        unique case (q_ff.qtr)
          2'h0: nxt_q.sda_low = ack_ph ? (rd && q_ff.step != STEP_LAST) : (!rd && !q_ff.sh[7]);
          2'h1: nxt_q.scl_low = 1'b0;
          2'h2: begin
            if (ack_ph) begin
              if (!rd) nxt_q.sh[0] = sda_s;
            end else begin
              nxt_q.sh = {q_ff.sh[6:0], rd & sda_s};
            end
          end
          2'h3: begin
            nxt_q.scl_low = 1'b1;
            nxt_q.bitn = ack_ph ? 4'h0 : q_ff.bitn + 4'h1;
            if (ack_ph) begin
              nxt_q.step = q_ff.step + 4'h1;
              if (!rd && q_ff.sh[0]) begin
                nxt_q.ld = LD_FAIL;
              end else if (rd && idx == 0 && q_ff.sh != SIGNATURE) begin
                nxt_q.ld = LD_FAIL;
              end else begin
                if (rd && idx >= 1 && idx <= 2) nxt_q.eq_reg[8 * (idx - 1) +: 8] = q_ff.sh;
                if (rd && idx >= 3) nxt_q.sw_reg[8 * (idx - 3) +: 8] = q_ff.sh;
                if (q_ff.step == STEP_LAST) nxt_q.ld = LD_STOP;
                else if (q_ff.step == 4'h1) nxt_q.ld = LD_START;
                else nxt_q.sh = (q_ff.step == 4'h0) ? EE_START_WORD : 8'h00;
              end
            end
          end
        endcase
      end
      LD_STOP: if (tick) begin
        unique case (q_ff.qtr)
          2'h0: nxt_q.sda_low = 1'b1;
          2'h1: nxt_q.scl_low = 1'b0;
          2'h2: nxt_q.sda_low = 1'b0;
          2'h3: nxt_q.ld = LD_PASS;
        endcase
      end
      LD_PASS, LD_FAIL: begin
        // Lines go back to inputs; a failed load is never retried.
        nxt_q.scl_low = 1'b0;
        nxt_q.sda_low = 1'b0;
      end
      default: nxt_q.ld = LD_FAIL;
    endcase

    refused = (q_ff.mode == MODE_MASTER) && (q_ff.ld != LD_PASS);

    // AXI4-Lite write path: address and data are taken in either order.
    if (awvalid_in && q_ff.awready) begin
      nxt_q.aw_held = 1'b1;
      nxt_q.awaddr = awaddr_in;
    end
    if (wvalid_in && q_ff.wready) begin
      nxt_q.w_held = 1'b1;
      nxt_q.wdata = wdata_in;
      nxt_q.wstrb = wstrb_in;
    end
    if (q_ff.bvalid && bready_in) nxt_q.bvalid = 1'b0;
    if (q_ff.aw_held && q_ff.w_held && !q_ff.bvalid) begin
      nxt_q.aw_held = 1'b0;
      nxt_q.w_held = 1'b0;
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp = RESP_OKAY;
      for (int b = 0; b < 4; b++) begin
        merged[8 * b +: 8] = q_ff.wstrb[b] ? q_ff.wdata[8 * b +: 8] : 8'h00;
      end
      unique case (q_ff.awaddr)
        ADDR_STATUS, ADDR_SLAVE_ADDR: nxt_q.bresp = RESP_OKAY;
        ADDR_LANE_EQ, ADDR_CTRL, ADDR_LANE_SWING: begin
          if (refused) begin
            nxt_q.bresp = RESP_SLVERR;
          end else begin
            for (int b = 0; b < 4; b++) begin
              if (q_ff.wstrb[b] && q_ff.awaddr == ADDR_LANE_SWING)
                nxt_q.sw_reg[8 * b +: 8] = merged[8 * b +: 8];
              if (q_ff.wstrb[b] && b < 2 && q_ff.awaddr == ADDR_LANE_EQ)
                nxt_q.eq_reg[8 * b +: 8] = merged[8 * b +: 8];
            end
            if (q_ff.awaddr == ADDR_CTRL && q_ff.wstrb[0]) nxt_q.ctrl = merged[2:0];
          end
        end
        ADDR_IRQ_STATUS: irq_clr = merged[2:0];
        ADDR_IRQ_MASK: if (q_ff.wstrb[0]) nxt_q.irq_mask = merged[2:0];
        default: nxt_q.bresp = RESP_DECERR;
      endcase
    end
    nxt_q.awready = !nxt_q.aw_held && !nxt_q.bvalid;
    nxt_q.wready = !nxt_q.w_held && !nxt_q.bvalid;

    // AXI4-Lite read path.
    if (q_ff.rvalid && rready_in) nxt_q.rvalid = 1'b0;
    if (arvalid_in && q_ff.arready) begin
      nxt_q.rvalid = 1'b1;
      nxt_q.rresp = RESP_OKAY;
      nxt_q.rdata = 32'h0;
      unique case (araddr_in)
        ADDR_STATUS: nxt_q.rdata = {25'h0, q_ff.smb_en, q_ff.ld, q_ff.load_status, q_ff.mode};
        ADDR_LANE_EQ: if (refused) nxt_q.rresp = RESP_SLVERR; else nxt_q.rdata = {16'h0, q_ff.eq_reg};
        ADDR_CTRL: if (refused) nxt_q.rresp = RESP_SLVERR; else nxt_q.rdata = {29'h0, q_ff.ctrl};
        ADDR_LANE_SWING: if (refused) nxt_q.rresp = RESP_SLVERR; else nxt_q.rdata = q_ff.sw_reg;
        ADDR_IRQ_STATUS: nxt_q.rdata = {29'h0, q_ff.irq_st};
        ADDR_IRQ_MASK: nxt_q.rdata = {29'h0, q_ff.irq_mask};
        ADDR_SLAVE_ADDR: nxt_q.rdata = {28'h0, q_ff.addr_out};
        default: nxt_q.rresp = RESP_DECERR;
      endcase
    end
    nxt_q.arready = !nxt_q.rvalid;

    // Pin functions follow the latched mode only.
    if (q_ff.mode == MODE_PIN) begin
      nxt_q.eq_out = q_ff.ctrl[CTRL_EQ_OVR] ? q_ff.eq_reg :
                     {{4{q_ff.s2[P_EQB +: 2]}}, {4{q_ff.s2[P_EQA +: 2]}}};
      nxt_q.sw_out = q_ff.ctrl[CTRL_SWING_OVR] ? q_ff.sw_reg :
                     {{4{q_ff.s2[P_SWB +: 4]}}, {4{q_ff.s2[P_SWA +: 4]}}};
      nxt_q.addr_out = 4'h0;
    end else begin
      nxt_q.eq_out = q_ff.eq_reg;
      nxt_q.sw_out = q_ff.sw_reg;
      nxt_q.addr_out = {q_ff.s2[P_EQB +: 2] == LVL_1, q_ff.s2[P_AD2],
                        q_ff.s2[P_SWB] , q_ff.s2[P_SWB + 2]};
    end
    // The threshold feeds only the detect status; in master mode the pin stays load request.
    nxt_q.thr_out = (q_ff.mode == MODE_MASTER) ? THR_DEFAULT : q_ff.s2[P_THR +: 2];
    nxt_q.load_status = (q_ff.mode == MODE_MASTER) ? (nxt_q.ld != LD_PASS) : !q_ff.sampled;
    nxt_q.smb_en = q_ff.sampled && q_ff.mode != MODE_PIN && !refused;

    // Sticky events; a new event outweighs a clear in the same cycle.
    ev[IRQ_LOAD_PASS] = q_ff.ld != LD_PASS && nxt_q.ld == LD_PASS;
    ev[IRQ_LOAD_FAIL] = q_ff.ld != LD_FAIL && nxt_q.ld == LD_FAIL;
    ev[IRQ_BUS_EDGE] = q_ff.smb_en && q_ff.s2[P_SCL] && !q_ff.scl_prev;
    nxt_q.irq_st = (q_ff.irq_st & ~irq_clr) | ev;
    nxt_q.irq = |(nxt_q.irq_st & nxt_q.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n_out = !q_ff.scl_low;
  assign sda_oe_n_out = !q_ff.sda_low;
  assign mode_out = q_ff.mode;
  assign load_status_out = q_ff.load_status;
  assign smbus_enable_out = q_ff.smb_en;
  assign slave_address_pins_out = q_ff.addr_out;
  assign eq_lane_out = q_ff.eq_out;
  assign swing_lane_out = q_ff.sw_out;
  assign detect_threshold_out = q_ff.thr_out;
  assign sigdet_readback_en_out = q_ff.ctrl[CTRL_SIGDET_RB];
  assign irq_out = q_ff.irq;
  assign awready_out = q_ff.awready;
  assign wready_out = q_ff.wready;
  assign bvalid_out = q_ff.bvalid;
  assign bresp_out = q_ff.bresp;
  assign arready_out = q_ff.arready;
  assign rvalid_out = q_ff.rvalid;
  assign rresp_out = q_ff.rresp;
  assign rdata_out = q_ff.rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  a_mode_decode_once: assert property (q_ff.sampled && !$past(q_ff.sampled) |->
    (q_ff.mode == MODE_SLAVE) == ($past(q_ff.s2[P_MODE +: 2]) == LVL_1))
    else $error("mode strap decoded wrongly");
  a_mode_stays_put: assert property (q_ff.sampled |=> $stable(q_ff.mode))
    else $error("mode changed after it was latched");
  a_load_low_start: assert property (q_ff.ld == LD_IDLE && q_ff.sampled &&
    q_ff.mode == MODE_MASTER && q_ff.s2[P_THR +: 2] == LVL_0 |=> q_ff.ld == LD_START)
    else $error("load request ignored");
  a_scl_input_done: assert property (q_ff.mode == MODE_MASTER && !load_status_out |->
    scl_oe_n_out && sda_oe_n_out)
    else $error("bus still driven after load passed");
  a_fail_hangs_high: assert property (q_ff.ld == LD_FAIL |=> q_ff.ld == LD_FAIL ##1
    load_status_out && !smbus_enable_out)
    else $error("failed load left its hang state");
  a_fail_refuse_read: assert property (q_ff.ld == LD_FAIL && arvalid_in && arready_out &&
    araddr_in == ADDR_LANE_EQ |=> rvalid_out && rresp_out == RESP_SLVERR)
    else $error("register read allowed after failed load");
  a_status_low_pass: assert property (q_ff.mode == MODE_MASTER && q_ff.ld == LD_PASS |->
    !load_status_out)
    else $error("load status high after pass");
  a_pin_group_eq: assert property (q_ff.mode == MODE_PIN && !q_ff.ctrl[CTRL_EQ_OVR] |=>
    eq_lane_out[7:0] == {4{$past(q_ff.s2[P_EQA +: 2])}})
    else $error("group A lanes not on common strap level");
  a_smb_address_pins: assert property (q_ff.mode != MODE_PIN |=>
    slave_address_pins_out[3] == ($past(q_ff.s2[P_EQB +: 2]) == LVL_1))
    else $error("address bit three not from group B strap");
  a_smb_lane_regs: assert property (q_ff.mode != MODE_PIN |=>
    swing_lane_out == $past(q_ff.sw_reg) && eq_lane_out == $past(q_ff.eq_reg))
    else $error("lanes not under register control");
  a_thr_master_fixed: assert property (q_ff.mode == MODE_MASTER |=>
    detect_threshold_out == THR_DEFAULT)
    else $error("load request pin used as threshold");

  c_load_pass: cover property (q_ff.ld == LD_STOP ##[1:20] q_ff.ld == LD_PASS);
  c_load_fail: cover property (q_ff.ld == LD_BIT ##1 q_ff.ld == LD_FAIL);
  c_irq_raised: cover property (!irq_out ##1 irq_out);

endmodule

// ---- include/repeater_cfg_pkg.sv ----
/*
  Constants, encodings and register map of the repeater configuration control block.
  Assumes that four-level strap pads are resolved outside into two-bit level codes.
*/
package repeater_cfg_pkg;

  // Four-level strap codes as delivered by the pad comparators.
  localparam logic [1:0] LVL_0 = 2'h0;
  localparam logic [1:0] LVL_R = 2'h1;
  localparam logic [1:0] LVL_F = 2'h2;
  localparam logic [1:0] LVL_1 = 2'h3;

  typedef enum logic [1:0] {MODE_PIN = 2'b00, MODE_SLAVE = 2'b01, MODE_MASTER = 2'b10} mode_t;
  typedef enum logic [2:0] {
    LD_IDLE = 3'b000, LD_START = 3'b001, LD_BIT = 3'b010,
    LD_STOP = 3'b011, LD_PASS = 3'b100, LD_FAIL = 3'b101
  } ld_t;

  // Bit positions of the synchronised pin vector.
  localparam int P_SDA = 0;
  localparam int P_SCL = 1;
  localparam int P_AD2 = 2;
  localparam int P_THR = 3;
  localparam int P_SWB = 5;
  localparam int P_SWA = 9;
  localparam int P_EQB = 13;
  localparam int P_EQA = 15;
  localparam int P_MODE = 17;
  localparam int SYNC_W = 19;

  // Register byte offsets.
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_LANE_EQ = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_LANE_SWING = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_SLAVE_ADDR = 8'h18;
  localparam int CTRL_EQ_OVR = 0;
  localparam int CTRL_SWING_OVR = 1;
  localparam int CTRL_SIGDET_RB = 2;
  localparam int IRQ_LOAD_PASS = 0;
  localparam int IRQ_LOAD_FAIL = 1;
  localparam int IRQ_BUS_EDGE = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [15:0] EQ_RESET = 16'h0000;
  localparam logic [31:0] SWING_RESET = 32'h0000_0000;
  localparam logic [1:0] THR_DEFAULT = LVL_F;

  // EEPROM image: signature, two equalizer bytes, four swing bytes.
  localparam logic [7:0] EE_WR_CMD = 8'ha0;
  localparam logic [7:0] EE_RD_CMD = 8'ha1;
  localparam logic [7:0] EE_START_WORD = 8'h00;
  localparam logic [3:0] STEP_FIRST_RD = 4'h3;
  localparam logic [3:0] STEP_LAST = 4'h9;
  localparam logic [1:0] BOOT_WAIT = 2'h3;

  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 800;
  localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  function automatic mode_t mode_decode(input logic [1:0] lvl);
    if (lvl == LVL_1) return MODE_SLAVE;
    if (lvl == LVL_F) return MODE_MASTER;
    return MODE_PIN;
  endfunction

endpackage

// ---- bench/eeprom_model.sv ----
/*
  Behavioural configuration EEPROM on an open-drain two-wire bus.
  Assumes both wires are resolved outside with pull-ups; it only ever pulls SDA low.
*/
`timescale 1ns/100ps
module eeprom_model
  import repeater_cfg_pkg::*;
(
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [6:0][7:0] image_in,
  output logic sda_pull_out
);
  logic [3:0] bit_ff;
  logic [2:0] byte_ff;
  logic rd_ff;
  logic [7:0] sh_ff;

  initial begin
    bit_ff = 4'h0;
    byte_ff = 3'h0;
    rd_ff = 1'b0;
    sh_ff = 8'h00;
    sda_pull_out = 1'b0;
  end

  // A falling SDA while SCL is high is a start; it restarts the byte framing.
  always @(negedge sda_in) begin
    if (scl_in) begin
      bit_ff = 4'h0;
      byte_ff = 3'h0;
      rd_ff = 1'b0;
    end
  end

  always @(posedge scl_in) begin
    if (bit_ff < 4'h8) begin
      sh_ff = {sh_ff[6:0], sda_in};
      bit_ff = bit_ff + 4'h1;
    end else begin
      bit_ff = 4'h0;
      if (rd_ff) byte_ff = byte_ff + 3'h1;
      else if (sh_ff == EE_RD_CMD) rd_ff = 1'b1;
    end
  end

  // Data changes only while SCL is low; the line is released after the last byte.
  always @(negedge scl_in) begin
    sda_pull_out <= (!rd_ff && bit_ff == 4'h8) ||
                    (rd_ff && bit_ff < 4'h8 && byte_ff < 3'h7 &&
                     !image_in[byte_ff][3'h7 - bit_ff[2:0]]);
  end
endmodule

// ---- bench/tb.sv ----
/*
  Self-checking bench for the repeater configuration control: pin, slave and master modes.
  Assumes the EEPROM model file and the design package are compiled first.
*/
`timescale 1ns/100ps
module tb
  import repeater_cfg_pkg::*;
;
  localparam logic [7:0] SIG = 8'h5a; // Arbitrary image marker.
  logic clk_in, arst_n_in, address_pin_two_in, scl_in, sda_in, tb_scl, pull;
  logic [1:0] config_mode_select_in, eq_level_group_a_in, eq_level_group_b_in;
  logic [1:0] detect_threshold_sel_in, mode_out, detect_threshold_out;
  logic [3:0] swing_group_a_in, swing_group_b_in, wstrb_in, slave_address_pins_out;
  logic scl_out, scl_oe_n_out, sda_out, sda_oe_n_out, load_status_out, smbus_enable_out;
  logic sigdet_readback_en_out, irq_out, awvalid_in, awready_out, wvalid_in, wready_out;
  logic bvalid_out, bready_in, arvalid_in, arready_out, rvalid_out, rready_in;
  logic [15:0] eq_lane_out;
  logic [31:0] swing_lane_out, wdata_in, rdata_out;
  logic [7:0] awaddr_in, araddr_in;
  logic [1:0] bresp_out, rresp_out;
  logic [6:0][7:0] image;
  int mismatches, comparisons, cyc, scl_falls;

  assign scl_in = (scl_oe_n_out | scl_out) & tb_scl;
  assign sda_in = (sda_oe_n_out | sda_out) & ~pull;

  repeater_config_mode_control #(.SIGNATURE(SIG)) i_dut (.clk_in, .arst_n_in,
    .config_mode_select_in, .eq_level_group_a_in, .eq_level_group_b_in, .swing_group_a_in,
    .swing_group_b_in, .detect_threshold_sel_in, .address_pin_two_in, .scl_in, .scl_out,
    .scl_oe_n_out, .sda_in, .sda_out, .sda_oe_n_out, .mode_out, .load_status_out,
    .smbus_enable_out, .slave_address_pins_out, .eq_lane_out, .swing_lane_out,
    .detect_threshold_out, .sigdet_readback_en_out, .irq_out, .awaddr_in, .awvalid_in,
    .awready_out, .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out,
    .bready_in, .araddr_in, .arvalid_in, .arready_out, .rdata_out, .rresp_out, .rvalid_out,
    .rready_in);

  eeprom_model i_eeprom (.scl_in(scl_in), .sda_in(sda_in), .image_in(image),
    .sda_pull_out(pull));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  always @(negedge scl_in) scl_falls++;

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rst(input logic [1:0] m, input logic [1:0] th);
    arst_n_in <= 1'b0;
    config_mode_select_in <= m;
    detect_threshold_sel_in <= th;
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (10) @(posedge clk_in);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_in);
    {awaddr_in, wdata_in, wstrb_in} <= {a, d, 4'hf};
    {awvalid_in, wvalid_in, bready_in} <= 3'h7;
    do begin
      @(posedge clk_in);
      if (awready_out) awvalid_in <= 1'b0;
      if (wready_out) wvalid_in <= 1'b0;
    end while (!bvalid_out);
    bready_in <= 1'b0;
    chk("bresp", er, bresp_out);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_in);
    araddr_in <= a;
    {arvalid_in, rready_in} <= 2'h3;
    do begin
      @(posedge clk_in);
      if (arready_out) arvalid_in <= 1'b0;
    end while (!rvalid_out);
    rready_in <= 1'b0;
    chk("rresp", er, rresp_out);
    if (er != RESP_DECERR) chk("rdata", ed, rdata_out);
  endtask

  //////////////////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n_in, awaddr_in, awvalid_in, wdata_in, wstrb_in, wvalid_in, bready_in} = '0;
    {araddr_in, arvalid_in, rready_in, config_mode_select_in} = '0;
    address_pin_two_in = 1'b0;
    tb_scl = 1'b1;
    image = {8'h78, 8'h56, 8'h34, 8'h12, 8'he4, 8'h1b, SIG};
    {eq_level_group_a_in, eq_level_group_b_in} = {2'h1, 2'h2};
    {swing_group_a_in, swing_group_b_in, detect_threshold_sel_in} = {4'h6, 4'h9, 2'h1};
    rst(LVL_0, 2'h1);
    chk("mode", MODE_PIN, mode_out);
    chk("eq", 16'haa55, eq_lane_out);
    chk("swing", 32'h9999_6666, swing_lane_out);
    chk("thr", 2'h1, detect_threshold_out);
    chk("addr", 4'h0, slave_address_pins_out);
    chk("smb", 1'b0, smbus_enable_out);
    chk("done", 1'b0, load_status_out);
    // Slave mode: address is {eq B high, pin two, swing B bit 0, swing B bit 2}.
    {eq_level_group_b_in, address_pin_two_in, swing_group_b_in} <= {LVL_1, 1'b1, 4'h1};
    rst(LVL_1, 2'h2);
    chk("mode", MODE_SLAVE, mode_out);
    chk("addr", 4'he, slave_address_pins_out);
    chk("thr", 2'h2, detect_threshold_out);
    config_mode_select_in <= LVL_0;
    repeat (8) @(posedge clk_in);
    chk("mode", MODE_SLAVE, mode_out);
    axr(ADDR_SLAVE_ADDR, 32'he, RESP_OKAY);
    axr(ADDR_STATUS, 32'h41, RESP_OKAY);
    axw(ADDR_LANE_EQ, 32'hc3a5, RESP_OKAY);
    axr(ADDR_LANE_EQ, 32'hc3a5, RESP_OKAY);
    chk("eq", 16'hc3a5, eq_lane_out);
    axw(ADDR_CTRL, 32'h4, RESP_OKAY);
    chk("sigdet", 1'b1, sigdet_readback_en_out);
    axr(8'h40, 32'h0, RESP_DECERR);
    axw(8'h40, 32'h0, RESP_DECERR);
    axw(ADDR_IRQ_STATUS, 32'h7, RESP_OKAY);
    axw(ADDR_IRQ_MASK, 32'h4, RESP_OKAY);
    chk("irq", 1'b0, irq_out);
    tb_scl <= 1'b0;
    repeat (4) @(posedge clk_in);
    tb_scl <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk("irq", 1'b1, irq_out);
    axr(ADDR_IRQ_STATUS, 32'h4, RESP_OKAY);
    axw(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
    repeat (2) @(posedge clk_in);
    chk("irq", 1'b0, irq_out);
    axw(ADDR_IRQ_MASK, 32'h4, RESP_OKAY);
    repeat (2) @(posedge clk_in);
    chk("irq", 1'b1, irq_out);
    axw(ADDR_IRQ_STATUS, 32'h4, RESP_OKAY);
    repeat (2) @(posedge clk_in);
    chk("irq", 1'b0, irq_out);
    // Master mode, good image: nothing moves until the request pin goes low.
    rst(LVL_F, 2'h3);
    repeat (50) @(posedge clk_in);
    chk("done", 1'b1, load_status_out);
    chk("scl_oe_n", 1'b1, scl_oe_n_out);
    axr(ADDR_LANE_EQ, 32'h0, RESP_SLVERR);
    scl_falls = 0;
    detect_threshold_sel_in <= 2'h0;
    while (load_status_out) begin
      @(posedge clk_in);
    end
    repeat (2) @(posedge clk_in);
    chk("done", 1'b0, load_status_out);
    chk("eq", 16'he41b, eq_lane_out);
    chk("swing", 32'h7856_3412, swing_lane_out);
    chk("scl_used", 1'b1, scl_falls > 0);
    chk("scl_oe_n", 1'b1, scl_oe_n_out);
    chk("addr", 4'he, slave_address_pins_out);
    detect_threshold_sel_in <= 2'h3;
    repeat (8) @(posedge clk_in);
    chk("thr", 2'h2, detect_threshold_out);
    axr(ADDR_LANE_EQ, 32'he41b, RESP_OKAY);
    axr(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
    // Master mode, zeroed signature byte: the loader must give up and lock the registers.
    image[0] = 8'h00;
    rst(LVL_F, 2'h0);
    repeat (3000) @(posedge clk_in);
    chk("done", 1'b1, load_status_out);
    chk("smb", 1'b0, smbus_enable_out);
    chk("lines", 2'h3, {scl_oe_n_out, sda_oe_n_out});
    axr(ADDR_LANE_EQ, 32'h0, RESP_SLVERR);
    axw(ADDR_LANE_EQ, 32'hffff, RESP_SLVERR);
    repeat (2) @(posedge clk_in);
    chk("eq", 16'h0, eq_lane_out);
    axr(ADDR_IRQ_STATUS, 32'h2, RESP_OKAY);
    summarize();
  end
endmodule
